// ==== design/gss_gain_switcher.sv ====
// Gain set switcher: condition decode, lag filter and set blending
// Notes on behaviour
// - Auto tuning modes keep the base set
// - First two selection digits pick the condition
// - Compare chosen quantity against the switching level
// - Set change follows first-order lag, time in ms
// - Five loop quantities switch between base and alternate
// - Vibration stages carry four alternate values each
// - Model gain, vibration values switch on command only
module gss_gain_switcher #(
  parameter int unsigned TICK_CYCLES = gss_pkg::TICK_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [15:0] tuningModeSelect,
  input wire logic [15:0] switchConditionCode,
  input wire logic [15:0] switchLevel,
  input wire logic [15:0] switchTimeConstant,
  input wire logic switchCommand,
  input wire gss_pkg::gss_meas_t measured,
  input wire gss_pkg::gss_set_t baseSet,
  input wire gss_pkg::gss_set_t altSet,
  output gss_pkg::gss_set_t appliedSet,
  output logic gainSwitched
);

  // Tick counter width
  localparam int unsigned TW = $clog2(TICK_CYCLES);
  localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);
  // Divider needs one step per bit plus set up and apply
  localparam logic [4:0] DIV_LAST = 5'h10;

  // The divider must finish well inside one tick period
  if (TICK_CYCLES < 32) begin : gTickCheck
    $error("TICK_CYCLES must be at least 32");
  end

  // Condition state
  logic manualQ, manualD;
  logic switchQ, switchD;
  logic cmdModeQ, cmdModeD;
  logic [3:0] condSel; // First digit
  logic [3:0] condDir; // Second digit
  logic [15:0] qty; // Quantity under comparison
  logic atOrAbove;

  // Decode mode and condition, compare against the level
  always_comb begin
    condSel = switchConditionCode[gss_pkg::DIGIT0_LSB +: gss_pkg::DIGIT_W];
    condDir = switchConditionCode[gss_pkg::DIGIT1_LSB +: gss_pkg::DIGIT_W];
    // Anything but manual counts as auto tuning
    manualD = tuningModeSelect[3:0] == gss_pkg::TUNE_MANUAL;
    cmdModeD = condSel == gss_pkg::COND_CMD;
    qty = 16'h0000;
    unique case (condSel)
      gss_pkg::COND_FREQ: qty = measured.cmdFreq;
      gss_pkg::COND_DROOP: qty = measured.droopPulses;
      gss_pkg::COND_SPEED: qty = measured.motorSpeed;
      default: qty = 16'h0000;
    endcase
    atOrAbove = qty >= switchLevel;
    unique case (condSel)
      // Command switching follows the host's command level
      gss_pkg::COND_CMD: switchD = switchCommand;
      gss_pkg::COND_FREQ, gss_pkg::COND_DROOP, gss_pkg::COND_SPEED: begin
        // Unknown sense digits fall back to at-or-above
        switchD = (condDir == gss_pkg::DIR_BELOW) ? !atOrAbove : atOrAbove;
      end
      // Disabled or unknown condition keeps the base set
      default: switchD = 1'b0;
    endcase
    switchD = switchD && manualD;
  end

  // Register the decoded condition
  always_ff @(posedge core_clk) begin
    if (rst) begin
      manualQ <= 1'b0;
      switchQ <= 1'b0;
      cmdModeQ <= 1'b0;
    end else begin
      manualQ <= manualD;
      switchQ <= switchD;
      cmdModeQ <= cmdModeD;
    end
  end

  // Millisecond tick
  logic [TW-1:0] tickCntQ, tickCntD;
  logic tick;

  // Free running tick counter
  always_comb begin
    tick = tickCntQ == TICK_LAST;
    tickCntD = tick ? '0 : tickCntQ + TW'(1);
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      tickCntQ <= '0;
    end else begin
      tickCntQ <= tickCntD;
    end
  end

  // Lag filter on the blend fraction
  gss_pkg::gss_state_t stateQ, stateD;
  logic [16:0] mixQ, mixD; // Q16 blend fraction
  logic [16:0] numQ, numD; // Dividend, shifted out MSB first
  logic [16:0] remQ, remD; // Partial remainder
  logic [16:0] quotQ, quotD; // Quotient, step per tick
  logic [15:0] denQ, denD; // Time constant latched at start
  logic [4:0] cntQ, cntD; // Divide step counter
  logic upQ, upD; // Direction of the current step
  logic [16:0] target;
  logic [16:0] remShift;
  logic [16:0] step;

  // One tick step is (target - mix) / T, giving a time constant of T ms
  always_comb begin
    stateD = stateQ;
    mixD = mixQ;
    numD = numQ;
    remD = remQ;
    quotD = quotQ;
    denD = denQ;
    cntD = cntQ;
    upD = upQ;
    target = switchQ ? gss_pkg::MIX_FULL : gss_pkg::MIX_ZERO;
    remShift = {remQ[15:0], numQ[16]};
    step = (quotQ == 17'h00000) ? 17'h00001 : quotQ;
    unique case (stateQ)
      gss_pkg::GSS_IDLE: begin
        if (switchTimeConstant == 16'h0000) begin
          // Zero time constant: no filtering, jump at once
          mixD = target;
        end else if (tick && mixQ != target) begin
          upD = target > mixQ;
          numD = (target > mixQ) ? target - mixQ : mixQ - target;
          remD = 17'h00000;
          quotD = 17'h00000;
          denD = switchTimeConstant;
          cntD = 5'h00;
          stateD = gss_pkg::GSS_DIV;
        end
      end
      gss_pkg::GSS_DIV: begin
        // Restoring division, one quotient bit a cycle
        numD = {numQ[15:0], 1'b0};
        if (remShift >= {1'b0, denQ}) begin
          remD = remShift - {1'b0, denQ};
          quotD = {quotQ[15:0], 1'b1};
        end else begin
          remD = remShift;
          quotD = {quotQ[15:0], 1'b0};
        end
        cntD = cntQ + 5'h01;
        if (cntQ == DIV_LAST) begin
          stateD = gss_pkg::GSS_APPLY;
        end
      end
      gss_pkg::GSS_APPLY: begin
        // Step never exceeds the distance, so no overshoot; minimum 1
        mixD = upQ ? mixQ + step : mixQ - step;
        stateD = gss_pkg::GSS_IDLE;
      end
      default: stateD = gss_pkg::GSS_IDLE;
    endcase
    // Leaving manual mode drops back to the base set immediately
    if (!manualQ) begin
      mixD = gss_pkg::MIX_ZERO;
      stateD = gss_pkg::GSS_IDLE;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      stateQ <= gss_pkg::GSS_IDLE;
      mixQ <= gss_pkg::MIX_ZERO;
      numQ <= 17'h00000;
      remQ <= 17'h00000;
      quotQ <= 17'h00000;
      denQ <= 16'h0000;
      cntQ <= 5'h00;
      upQ <= 1'b0;
    end else begin
      stateQ <= stateD;
      mixQ <= mixD;
      numQ <= numD;
      remQ <= remD;
      quotQ <= quotD;
      denQ <= denD;
      cntQ <= cntD;
      upQ <= upD;
    end
  end

  // Blending of each value between its base and alternate
  logic [207:0] baseFlat, altFlat, blendFlat;
  logic [16:0] mixCmd; // Fraction for command-only values
  assign baseFlat = baseSet;
  assign altFlat = altSet;
  // Other conditions leave model gain and vibration values at base
  assign mixCmd = cmdModeQ ? mixQ : gss_pkg::MIX_ZERO;

  for (genvar i = 0; i < gss_pkg::NUM_VALS; i++) begin : gBlend
    logic [15:0] baseV, altV, outV;
    logic [16:0] mixUse;
    logic signed [16:0] diffS;
    logic signed [17:0] mixS;
    logic signed [34:0] prodS;
    logic signed [34:0] scaledS;
    logic [16:0] sumV;
    assign baseV = baseFlat[i*16 +: 16];
    assign altV = altFlat[i*16 +: 16];
    // Vibration stage values and model gain are command-only
    if (i < gss_pkg::VS_COUNT || i == gss_pkg::MODEL_IDX) begin : gCmd
      assign mixUse = mixCmd;
    end else begin : gAll
      assign mixUse = mixQ;
    end
    // base + (alt - base) * mix, exact at both ends of the fraction
    assign diffS = $signed({1'b0, altV}) - $signed({1'b0, baseV});
    assign mixS = $signed({1'b0, mixUse});
    assign prodS = diffS * mixS;
    assign scaledS = prodS >>> gss_pkg::MIX_FRAC;
    assign sumV = {1'b0, baseV} + scaledS[16:0];
    assign outV = sumV[15:0];
    assign blendFlat[i*16 +: 16] = outV;
  end

  // Registered outputs
  gss_pkg::gss_set_t appliedQ, appliedD;
  logic switchedOutQ, switchedOutD;

  always_comb begin
    appliedD = blendFlat;
    switchedOutD = switchQ;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      appliedQ <= gss_pkg::SET_RESET;
      switchedOutQ <= 1'b0;
    end else begin
      appliedQ <= appliedD;
      switchedOutQ <= switchedOutD;
    end
  end

  assign appliedSet = appliedQ;
  assign gainSwitched = switchedOutQ;

endmodule : gss_gain_switcher

// ==== design/gss_pkg.sv ====
// Constants and carrier types for the servo gain set switcher
package gss_pkg;

  // Core clock rate and the filter update period (one millisecond)
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned TICK_TIME_US = 1000;
  // Cycles per filter update, derived from rate and period
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_TIME_US;

  // Width of every switched value and of the level/time fields
  localparam int unsigned VAL_W = 16;
  // Number of switched values carried in one parameter set
  localparam int unsigned NUM_VALS = 13;
  // Flattened indices: 0..7 are the two vibration stages, 11 model gain
  localparam int unsigned VS_COUNT = 8;
  localparam int unsigned MODEL_IDX = 11;

  // Digit positions inside the selection words
  localparam int unsigned DIGIT0_LSB = 0;
  localparam int unsigned DIGIT1_LSB = 4;
  localparam int unsigned DIGIT_W = 4;

  // Lowest digit of the tuning mode word that means manual adjustment
  localparam logic [3:0] TUNE_MANUAL = 4'h3;

  // Switching condition, first digit of the selection word
  localparam logic [3:0] COND_OFF = 4'h0;
  localparam logic [3:0] COND_CMD = 4'h1;
  localparam logic [3:0] COND_FREQ = 4'h2;
  localparam logic [3:0] COND_DROOP = 4'h3;
  localparam logic [3:0] COND_SPEED = 4'h4;

  // Comparison sense, second digit of the selection word
  localparam logic [3:0] DIR_AT_OR_ABOVE = 4'h0;
  localparam logic [3:0] DIR_BELOW = 4'h1;

  // Blend fraction in Q16: zero is the base set, full is the alternate set
  localparam int unsigned MIX_W = 17;
  localparam logic [16:0] MIX_ZERO = 17'h00000;
  localparam logic [16:0] MIX_FULL = 17'h10000;
  localparam int unsigned MIX_FRAC = 16;

  // Reset value of the applied set
  localparam logic [207:0] SET_RESET = 208'h0;

  // Filter sequencer states
  typedef enum logic [1:0] {
    GSS_IDLE = 2'b00,
    GSS_DIV = 2'b01,
    GSS_APPLY = 2'b10
  } gss_state_t;

  // Five loop quantities
  typedef struct packed {
    logic [15:0] inertiaRatio;
    logic [15:0] modelGain;
    logic [15:0] positionGain;
    logic [15:0] speedGain;
    logic [15:0] integralComp;
  } gss_loop_t;

  // Four values of one vibration suppression stage
  typedef struct packed {
    logic [15:0] vibFreq;
    logic [15:0] resFreq;
    logic [15:0] vibDamp;
    logic [15:0] resDamp;
  } gss_vs_t;

  // One complete parameter set
  typedef struct packed {
    gss_loop_t loop;
    gss_vs_t vs1;
    gss_vs_t vs2;
  } gss_set_t;

  // Measured quantities from the control loops, unsigned magnitudes
  typedef struct packed {
    logic [15:0] cmdFreq;
    logic [15:0] droopPulses;
    logic [15:0] motorSpeed;
  } gss_meas_t;

endpackage : gss_pkg

// ==== sim/gss_gain_switcher_bench.sv ====
// Self-checking bench for the servo gain set switcher
module gss_gain_switcher_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, rst, autoReq, switchCommand, gainSwitched;
  logic [15:0] tuningModeSelect, switchConditionCode, switchLevel;
  logic [15:0] switchTimeConstant, speedIn;
  gss_pkg::gss_meas_t measured;
  gss_pkg::gss_set_t baseSet, altSet, appliedSet, expSet;
  int failures = 0;
  int total_checks = 0;
  int cycles = 0;
  int n;
  // Clock at 40 ns
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  gss_host_model host (.autoReq(autoReq), .speedIn(speedIn),
    .tuningModeSelect(tuningModeSelect), .measured(measured),
    .baseSet(baseSet), .altSet(altSet));
  // Short tick keeps the lag scenario brief
  gss_gain_switcher #(.TICK_CYCLES(40)) dut (.core_clk(core_clk), .rst(rst),
    .tuningModeSelect(tuningModeSelect),
    .switchConditionCode(switchConditionCode), .switchLevel(switchLevel),
    .switchTimeConstant(switchTimeConstant), .switchCommand(switchCommand),
    .measured(measured), .baseSet(baseSet), .altSet(altSet),
    .appliedSet(appliedSet), .gainSwitched(gainSwitched));
  task automatic chk(input string what, input logic [207:0] seen,
                     input logic [207:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic finish_test();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : finish_test
  // New setup after a falling edge, then settle
  task automatic drive(input logic [15:0] cond, input logic [15:0] tc,
                       input logic cmd, input logic au);
    @(negedge core_clk);
    switchConditionCode = cond;
    switchTimeConstant = tc;
    switchCommand = cmd;
    autoReq = au;
    repeat (5) @(negedge core_clk);
  endtask : drive
  // Hang guard
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      finish_test();
    end
  end
  initial begin
    rst = 1'b1;
    autoReq = 1'b0;
    switchCommand = 1'b0;
    switchConditionCode = 16'h0000;
    switchLevel = 16'h0064;
    switchTimeConstant = 16'h0000;
    speedIn = 16'h0096;
    repeat (2) @(negedge core_clk);
    rst = 1'b0;
    repeat (3) @(negedge core_clk);
    chk("reset set", appliedSet, baseSet);
    drive(16'h0001, 16'h0000, 1'b1, 1'b0);
    chk("cmd flag", gainSwitched, 1'b1);
    chk("cmd set", appliedSet, altSet);
    drive(16'h0001, 16'h0000, 1'b0, 1'b0);
    chk("cmd off", appliedSet, baseSet);
    // Level conditions move loop values except model gain, command is ignored
    expSet = altSet;
    expSet.loop.modelGain = baseSet.loop.modelGain;
    expSet.vs1 = baseSet.vs1;
    expSet.vs2 = baseSet.vs2;
    for (int c = 2; c <= 4; c++) begin
      drive(16'(c), 16'h0000, 1'b1, 1'b0);
      chk("level set", appliedSet, expSet);
      drive(16'(c) | 16'h0010, 16'h0000, 1'b0, 1'b0);
      chk("below off", gainSwitched, 1'b0);
    end
    speedIn = 16'h0032;
    drive(16'h0014, 16'h0000, 1'b0, 1'b0);
    chk("below on", gainSwitched, 1'b1);
    // A quantity equal to the level counts as reached
    speedIn = 16'h0064;
    drive(16'h0004, 16'h0000, 1'b0, 1'b0);
    chk("level equal", gainSwitched, 1'b1);
    drive(16'h0001, 16'h0000, 1'b1, 1'b1);
    chk("auto flag", gainSwitched, 1'b0);
    chk("auto set", appliedSet, baseSet);
    // Quarter step first, then settle on the alternate set
    drive(16'h0001, 16'h0004, 1'b1, 1'b0);
    n = 0;
    while (appliedSet === baseSet && n < 200) begin
      @(negedge core_clk);
      n++;
    end
    chk("first step", appliedSet.loop.speedGain, 16'h0CB2);
    n = 0;
    while (appliedSet !== altSet && n < 4000) begin
      @(negedge core_clk);
      n++;
    end
    chk("lag end", appliedSet, altSet);
    finish_test();
  end
endmodule : gss_gain_switcher_bench

// ==== sim/gss_host_model.sv ====
// Host and loop model: tuning word, measured values, both parameter sets
module gss_host_model (
  input wire logic autoReq,
  input wire logic [15:0] speedIn,
  output logic [15:0] tuningModeSelect,
  output gss_pkg::gss_meas_t measured,
  output gss_pkg::gss_set_t baseSet,
  output gss_pkg::gss_set_t altSet
);
  timeunit 1ns;
  timeprecision 1ps;
  // Manual adjustment unless an auto tuning mode is asked for
  assign tuningModeSelect = autoReq ? 16'h0001 : 16'h0003;
  // One magnitude on every channel so each condition sees it
  assign measured = {speedIn, speedIn, speedIn};
  // Every base value differs from its alternate
  assign baseSet = {13{16'h0BB8}};
  assign altSet = {13{16'h0FA0}};
endmodule : gss_host_model

// ==== sim/gss_props.sv ====
// Port checker for the servo gain set switcher
module gss_gain_switcher_props #(
  parameter int unsigned TICK_CYCLES = 40
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [15:0] tuningModeSelect,
  input wire logic [15:0] switchConditionCode,
  input wire logic [15:0] switchLevel,
  input wire logic [15:0] switchTimeConstant,
  input wire logic switchCommand,
  input wire gss_pkg::gss_meas_t measured,
  input wire gss_pkg::gss_set_t baseSet,
  input wire gss_pkg::gss_set_t altSet,
  input wire gss_pkg::gss_set_t appliedSet,
  input wire logic gainSwitched
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // Shorthands for the decoded selection
  wire logic manual = tuningModeSelect[3:0] == gss_pkg::TUNE_MANUAL;
  wire logic [3:0] cond = switchConditionCode[3:0];
  wire logic [3:0] sense = switchConditionCode[7:4];
  wire logic [15:0] spdA = altSet.loop.speedGain;

  property p_auto; !manual |-> ##2 !gainSwitched; endproperty
  a_auto: assert property (p_auto) else $error("switched in auto");
  // Mode flag, then fraction, then output register: base shows on the fourth
  property p_autobase; (!manual)[*4] |-> appliedSet == baseSet; endproperty
  a_autobase: assert property (p_autobase) else $error("auto set");
  property p_cmd; manual && cond == 4'h1 && switchCommand |-> ##2 gainSwitched;
  endproperty
  a_cmd: assert property (p_cmd) else $error("no cmd switch");
  property p_off; cond == 4'h0 |-> ##2 !gainSwitched; endproperty
  a_off: assert property (p_off) else $error("switched when off");
  property p_speed; manual && cond == 4'h4 && sense == 4'h0 &&
    measured.motorSpeed >= switchLevel |-> ##2 gainSwitched; endproperty
  a_speed: assert property (p_speed) else $error("no speed switch");
  property p_t0; (gainSwitched && cond == 4'h1 && switchTimeConstant == 0)[*3]
    |-> appliedSet == altSet; endproperty
  a_t0: assert property (p_t0) else $error("alt set missing");
  property p_model; (cond != 4'h1)[*3] |-> appliedSet.vs1 == baseSet.vs1 &&
    appliedSet.loop.modelGain == baseSet.loop.modelGain; endproperty
  a_model: assert property (p_model) else $error("model gain moved");
  // A slow lag may not reach the alternate value at once
  property p_lag; $rose(gainSwitched) && switchTimeConstant > 1 &&
    appliedSet == baseSet && baseSet != altSet
    |-> (appliedSet.loop.speedGain != spdA)[*8]; endproperty
  a_lag: assert property (p_lag) else $error("lag skipped");
  property p_fast; $rose(gainSwitched) && switchTimeConstant <= 1
    |-> ##[1:80] appliedSet.loop.speedGain == spdA; endproperty
  a_fast: assert property (p_fast) else $error("fast lag late");
  c_cmd: cover property ($rose(gainSwitched) && cond == 4'h1);
  c_level: cover property ($rose(gainSwitched) && cond == 4'h4);
  c_auto: cover property (!manual && switchCommand);
endmodule : gss_gain_switcher_props

bind gss_gain_switcher gss_gain_switcher_props #(.TICK_CYCLES(TICK_CYCLES))
  u_props (.core_clk(core_clk), .rst(rst),
  .tuningModeSelect(tuningModeSelect),
  .switchConditionCode(switchConditionCode), .switchLevel(switchLevel),
  .switchTimeConstant(switchTimeConstant), .switchCommand(switchCommand),
  .measured(measured), .baseSet(baseSet), .altSet(altSet),
  .appliedSet(appliedSet), .gainSwitched(gainSwitched));
